// file: mtc_pkg.sv
// Constants, address map and index helpers for the three-channel timer slice.
// Assumes a 16-bit register bus with byte lanes and byte addresses.
package mtc_pkg;
   // Sizes
   localparam int MTC_NCH = 3;
   localparam int MTC_NGR = 8;
   // Address map: channel c at c * stride, run control on its own
   localparam logic [7:0] MTC_CH_STRIDE = 8'h10;
   localparam logic [3:0] MTC_OFS_FLAGS = 4'h0;
   localparam logic [3:0] MTC_OFS_COUNT = 4'h2;
   localparam logic [3:0] MTC_OFS_GR_A = 4'h4;
   localparam logic [3:0] MTC_OFS_GR_D = 4'ha;
   localparam logic [7:0] MTC_OFS_RUN = 8'h30;
   // Reset values and counter top
   localparam logic [15:0] MTC_COUNT_RST = 16'h0000;
   localparam logic [15:0] MTC_GR_RST = 16'hffff;
   localparam logic [2:0] MTC_RUN_RST = 3'h0;
   localparam logic [15:0] MTC_COUNT_TOP = 16'hffff;
   // Event flag register fields
   localparam int MTC_BIT_WRAP = 4;
   localparam int MTC_BIT_UNDER = 5;
   localparam int MTC_BIT_FIXED = 6;
   localparam int MTC_BIT_DIR = 7;
   // Full 16-bit access on both byte lanes
   localparam logic [1:0] MTC_LANES_ALL = 2'h3;

   // Channel that owns general register i (0..3 ch0, 4..5 ch1, 6..7 ch2)
   function automatic int mtc_gr_ch(input int i);
      return (i < 4) ? 0 : ((i < 6) ? 1 : 2);
   endfunction

   // Position of general register i inside its channel
   function automatic int mtc_gr_k(input int i);
      return (i < 4) ? i : (i % 2);
   endfunction

   // True when the address is a 16-bit-only register (counter or general)
   function automatic logic mtc_is_wide(input logic [7:0] a);
      return (a != MTC_OFS_RUN) && (a[3:0] >= MTC_OFS_COUNT) && (a[3:0] <= MTC_OFS_GR_D);
   endfunction
endpackage

// file: mtc_bus_if.sv
// Register bus between the bus master (CPU or DMA) and the timer slice.
// Assumes both ends run on one clock; the device answers reads one cycle later.
interface mtc_bus_if;
   // Register access
   logic [7:0] addr;
   logic [15:0] wdata;
   logic [1:0] byte_en;
   logic wr;
   logic rd;
   logic [15:0] rdata;
   // DMA transfer done, naming the general register it was started by
   logic dma_fire;
   logic [2:0] dma_src;

   modport dev (input addr, input wdata, input byte_en, input wr, input rd, output rdata,
                input dma_fire, input dma_src);
   modport host (output addr, output wdata, output byte_en, output wr, output rd, input rdata,
                 output dma_fire, output dma_src);
endinterface

// file: mtc_timer_dev.sv
// Timer slice: three 16-bit counters, eight compare/capture registers,
// event flags with read-then-write-zero clear, and the run control register.
// Assumes count ticks, capture strobes and mode levels come from logic on ref_clk.

// What this block does
// - Compare match sets the register's flag
// - Capture load sets the register's flag
// - Flag clears by zero write after read
// - DMA service of a flag clears it
// - Channels 1, 2 bits 2, 3 read zero
// - Three 16-bit counters, reset to zero
// - Channel 0 up only; others down in phase
// - Counters accept only 16-bit writes
// - Eight general registers: four, two, two
// - General registers reset to all ones
// - General registers accept only 16-bit writes
// - Channel 0 C buffers A, D buffers B
// - Run register bits 2..0, upper bits zero
// - Software stops counter before mode changes
// - Stopping halts counter, pin level held
// - Stopped channel: pin control sets pin
// - Wrap from all ones sets wrap flag
// - Flag raises request only when enabled
module mtc_timer_dev (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register bus and DMA
   mtc_bus_if.dev b,
   // Count clock and mode
   input wire logic [mtc_pkg::MTC_NCH-1:0] count_tick,
   input wire logic [mtc_pkg::MTC_NCH-1:0] phase_mode,
   input wire logic [mtc_pkg::MTC_NCH-1:0] count_down,
   // Compare/capture setup
   input wire logic [mtc_pkg::MTC_NGR-1:0] is_capture,
   input wire logic [mtc_pkg::MTC_NGR-1:0] capture_in,
   input wire logic [1:0] buffer_en,
   input wire logic [mtc_pkg::MTC_NGR-1:0] match_level,
   // Pin control writes
   input wire logic [mtc_pkg::MTC_NCH-1:0] pin_io_wr,
   input wire logic [mtc_pkg::MTC_NGR-1:0] pin_init,
   // Interrupt enables
   input wire logic [mtc_pkg::MTC_NGR-1:0] irq_enable_bits,
   input wire logic [mtc_pkg::MTC_NCH-1:0] wrap_irq_en,
   // Outputs
   output logic [mtc_pkg::MTC_NGR-1:0] capture_compare_pin,
   output logic [mtc_pkg::MTC_NGR-1:0] match_irq,
   output logic [mtc_pkg::MTC_NCH-1:0] wrap_irq
);
   import mtc_pkg::*;

   logic [15:0] cnt_q [MTC_NCH];
   logic [15:0] gr_q [MTC_NGR];
   logic [2:0] run_q;
   logic [MTC_NGR-1:0] match_q, match_arm_q;
   logic [MTC_NCH-1:0] wrap_q, wrap_arm_q, under_q, under_arm_q, dir_q;
   logic [15:0] rdata_q;
   logic [15:0] cnt_nx [MTC_NCH];
   logic [MTC_NCH-1:0] step, down, ovf_evt, unf_evt, wr_cnt, wr_flags, rd_flags;
   logic [MTC_NGR-1:0] match_evt, cap_evt, wr_gr, clr_match;
   logic [MTC_NCH-1:0] clr_wrap, clr_under;
   logic wr_run;
   logic [15:0] rdata_d;
   logic [7:0] flags_byte [MTC_NCH];

   // Address decode; counter and general writes need both byte lanes
   always_comb begin
      wr_cnt = '0;
      wr_flags = '0;
      rd_flags = '0;
      wr_gr = '0;
      wr_run = 1'b0;
      if (b.addr == MTC_OFS_RUN) begin
         wr_run = b.wr & b.byte_en[0];
      end else if (b.addr[7:4] < 4'(MTC_NCH)) begin
         for (int c = 0; c < MTC_NCH; c++) begin
            if (b.addr[7:4] == 4'(c)) begin
               if (b.addr[3:0] == MTC_OFS_FLAGS) begin
                  wr_flags[c] = b.wr & b.byte_en[0];
                  rd_flags[c] = b.rd;
               end else if (b.addr[3:0] == MTC_OFS_COUNT) begin
                  wr_cnt[c] = b.wr & (b.byte_en == MTC_LANES_ALL);
               end
            end
         end
         for (int i = 0; i < MTC_NGR; i++) begin
            if (b.addr[7:4] == 4'(mtc_gr_ch(i)) && b.addr[3:0] == MTC_OFS_GR_A + 4'(2 * mtc_gr_k(i))) begin
               wr_gr[i] = b.wr & (b.byte_en == MTC_LANES_ALL);
            end
         end
      end
   end

   // Counter step and wrap detection per channel
   always_comb begin
      for (int c = 0; c < MTC_NCH; c++) begin
         step[c] = count_tick[c] & run_q[c];
         down[c] = (c != 0) & phase_mode[c] & count_down[c];
         cnt_nx[c] = down[c] ? cnt_q[c] - 16'h0001 : cnt_q[c] + 16'h0001;
         ovf_evt[c] = step[c] & ~down[c] & (cnt_q[c] == MTC_COUNT_TOP);
         unf_evt[c] = step[c] & down[c] & (cnt_q[c] == MTC_COUNT_RST);
      end
   end

   // Match fires as the counter lands on the value; capture on the strobe
   always_comb begin
      for (int i = 0; i < MTC_NGR; i++) begin
         match_evt[i] = ~is_capture[i] & step[mtc_gr_ch(i)] & (cnt_nx[mtc_gr_ch(i)] == gr_q[i]);
         cap_evt[i] = is_capture[i] & capture_in[i];
         clr_match[i] = (wr_flags[mtc_gr_ch(i)] & match_arm_q[i] & ~b.wdata[mtc_gr_k(i)])
                      | (b.dma_fire & (b.dma_src == 3'(i)) & match_irq[i]);
      end
      for (int c = 0; c < MTC_NCH; c++) begin
         clr_wrap[c] = wr_flags[c] & wrap_arm_q[c] & ~b.wdata[MTC_BIT_WRAP];
         clr_under[c] = wr_flags[c] & under_arm_q[c] & ~b.wdata[MTC_BIT_UNDER];
      end
   end

   // Counters; a bus write wins over a tick in the same cycle
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int c = 0; c < MTC_NCH; c++) cnt_q[c] <= MTC_COUNT_RST;
      end else begin
         for (int c = 0; c < MTC_NCH; c++) begin
            if (wr_cnt[c]) begin
               cnt_q[c] <= b.wdata;
            end else if (step[c]) begin
               cnt_q[c] <= cnt_nx[c];
            end
         end
      end
   end

   // General registers; partner i^2 pairs A with C and B with D
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < MTC_NGR; i++) gr_q[i] <= MTC_GR_RST;
      end else begin
         for (int i = 0; i < MTC_NGR; i++) begin
            if (cap_evt[i]) begin
               gr_q[i] <= cnt_q[mtc_gr_ch(i)];
            end else if (i >= 2 && i < 4 && buffer_en[i % 2] && cap_evt[i ^ 2]) begin
               gr_q[i] <= gr_q[i ^ 2];
            end else if (i < 2 && buffer_en[i % 2] && match_evt[i]) begin
               gr_q[i] <= gr_q[i ^ 2];
            end else if (wr_gr[i]) begin
               gr_q[i] <= b.wdata;
            end
         end
      end
   end

   // Run control
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         run_q <= MTC_RUN_RST;
      end else if (wr_run) begin
         run_q <= b.wdata[2:0];
      end
   end

   // Match flags; arming on read lets only a seen 1 be cleared
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         match_q <= '0;
         match_arm_q <= '0;
      end else begin
         match_q <= (match_q & ~clr_match) | match_evt | cap_evt;
         for (int i = 0; i < MTC_NGR; i++) begin
            if (rd_flags[mtc_gr_ch(i)]) begin
               match_arm_q[i] <= match_q[i];
            end else if (clr_match[i]) begin
               match_arm_q[i] <= 1'b0;
            end
         end
      end
   end

   // Wrap, underflow and direction flags per channel
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         wrap_q <= '0;
         wrap_arm_q <= '0;
         under_q <= '0;
         under_arm_q <= '0;
         dir_q <= '1;
      end else begin
         wrap_q <= (wrap_q & ~clr_wrap) | ovf_evt;
         under_q <= (under_q & ~clr_under) | unf_evt;
         for (int c = 0; c < MTC_NCH; c++) begin
            if (rd_flags[c]) begin
               wrap_arm_q[c] <= wrap_q[c];
               under_arm_q[c] <= under_q[c];
            end else begin
               wrap_arm_q[c] <= wrap_arm_q[c] & ~clr_wrap[c];
               under_arm_q[c] <= under_arm_q[c] & ~clr_under[c];
            end
            if (step[c]) dir_q[c] <= ~down[c];
         end
      end
   end

   // Flag byte view; channels 1 and 2 have only A and B
   always_comb begin
      for (int c = 0; c < MTC_NCH; c++) begin
         flags_byte[c] = 8'h00;
         flags_byte[c][MTC_BIT_DIR] = dir_q[c];
         flags_byte[c][MTC_BIT_FIXED] = 1'b1;
         flags_byte[c][MTC_BIT_UNDER] = (c != 0) & under_q[c];
         flags_byte[c][MTC_BIT_WRAP] = wrap_q[c];
      end
      for (int i = 0; i < MTC_NGR; i++) begin
         flags_byte[mtc_gr_ch(i)][mtc_gr_k(i)] = match_q[i];
      end
   end

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rdata_d = 16'h0000;
      if (b.addr == MTC_OFS_RUN) begin
         rdata_d = {13'h0000, run_q};
      end else if (b.addr[7:4] < 4'(MTC_NCH)) begin
         for (int c = 0; c < MTC_NCH; c++) begin
            if (b.addr[7:4] == 4'(c) && b.addr[3:0] == MTC_OFS_FLAGS) rdata_d = {8'h00, flags_byte[c]};
            if (b.addr[7:4] == 4'(c) && b.addr[3:0] == MTC_OFS_COUNT) rdata_d = cnt_q[c];
         end
         for (int i = 0; i < MTC_NGR; i++) begin
            if (b.addr[7:4] == 4'(mtc_gr_ch(i)) && b.addr[3:0] == MTC_OFS_GR_A + 4'(2 * mtc_gr_k(i))) begin
               rdata_d = gr_q[i];
            end
         end
      end
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_q <= 16'h0000;
      end else begin
         rdata_q <= b.rd ? rdata_d : 16'h0000;
      end
   end
   assign b.rdata = rdata_q;

   // Pins: matches move them; a stopped channel takes the pin control level
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         capture_compare_pin <= '0;
      end else begin
         for (int i = 0; i < MTC_NGR; i++) begin
            if (pin_io_wr[mtc_gr_ch(i)] & ~run_q[mtc_gr_ch(i)]) begin
               capture_compare_pin[i] <= pin_init[i];
            end else if (match_evt[i]) begin
               capture_compare_pin[i] <= match_level[i];
            end
         end
      end
   end

   // Requests registered so they come straight from flops
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         match_irq <= '0;
         wrap_irq <= '0;
      end else begin
         match_irq <= match_q & irq_enable_bits;
         wrap_irq <= wrap_q & wrap_irq_en;
      end
   end
endmodule

// file: mtc_bus_host.sv
// Bus master end: forwards software and DMA orders onto the timer's bus.
// Assumes a plain command port; read data return three cycles after the strobe.
module mtc_bus_host (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Bus to the timer
   mtc_bus_if.host b,
   // Software command port
   input wire logic [7:0] cmd_addr,
   input wire logic [15:0] cmd_wdata,
   input wire logic [1:0] cmd_byte_en,
   input wire logic cmd_wr,
   input wire logic cmd_rd,
   output logic [15:0] cmd_rdata,
   output logic cmd_rvalid,
   // DMA completion
   input wire logic dma_done,
   input wire logic [2:0] dma_request_select
);
   import mtc_pkg::*;

   logic [7:0] addr_q;
   logic [15:0] wdata_q;
   logic [1:0] be_q;
   logic wr_q, rd_q, rd_wait_q, dma_q;
   logic [2:0] src_q;

   // One registered stage; wide registers always get both lanes
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         addr_q <= 8'h00;
         wdata_q <= 16'h0000;
         be_q <= 2'h0;
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         dma_q <= 1'b0;
         src_q <= 3'h0;
      end else begin
         addr_q <= cmd_addr;
         wdata_q <= cmd_wdata;
         be_q <= mtc_is_wide(cmd_addr) ? MTC_LANES_ALL : cmd_byte_en;
         wr_q <= cmd_wr;
         rd_q <= cmd_rd; // Software reads a flag before zeroing it
         dma_q <= dma_done;
         src_q <= dma_request_select;
      end
   end
   assign b.addr = addr_q;
   assign b.wdata = wdata_q;
   assign b.byte_en = be_q;
   assign b.wr = wr_q;
   assign b.rd = rd_q;
   assign b.dma_fire = dma_q;
   assign b.dma_src = src_q;

   // Read return captured from the device's answer cycle
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rd_wait_q <= 1'b0;
         cmd_rdata <= 16'h0000;
         cmd_rvalid <= 1'b0;
      end else begin
         rd_wait_q <= rd_q;
         cmd_rvalid <= rd_wait_q;
         cmd_rdata <= rd_wait_q ? b.rdata : 16'h0000;
      end
   end
endmodule

// file: mtc_bus_monitor.sv
// Checker for the register bus between the bus master end and the timer slice.
// Assumes it is instantiated beside the interface and sees its signals only.
module mtc_bus_monitor (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Bus signals
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [1:0] byte_en,
   input wire logic wr,
   input wire logic rd,
   input wire logic [15:0] rdata,
   input wire logic dma_fire,
   input wire logic [2:0] dma_src
);
   import mtc_pkg::*;

   // One clock domain, so one default for all properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Strobes never overlap
   a_strobes_exclusive: assert property (!(wr && rd)) else $error("wr and rd high together");
   // Read data only in the cycle after a read
   a_rdata_idle_zero: assert property (!rd |=> rdata == 16'h0000) else $error("rdata not zero");
   // Wide registers always get both lanes
   a_wide_full_lanes: assert property ((wr || rd) && mtc_is_wide(addr) |-> byte_en == MTC_LANES_ALL)
      else $error("narrow access to wide register");
   // Run register upper bits read zero
   a_run_upper_zero: assert property (rd && addr == MTC_OFS_RUN |=> rdata[15:3] == 13'h0000)
      else $error("run register upper bits set");
   // Channels 1 and 2 have no flags C and D
   a_no_flags_cd: assert property (rd && (addr == 8'h10 || addr == 8'h20) |=> rdata[3:2] == 2'h0)
      else $error("flag C or D seen in channel 1 or 2");
   // Channel 0 always shows counting up
   a_ch0_dir_up: assert property (rd && addr == 8'h00 |=> rdata[7]) else $error("ch0 direction not up");
   // Channel 0 never underflows
   a_ch0_no_under: assert property (rd && addr == 8'h00 |=> !rdata[5]) else $error("ch0 underflow bit set");
   // Space above the run register reads zero
   a_unmapped_zero: assert property (rd && addr > MTC_OFS_RUN |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
   // DMA completion is a single pulse
   a_dma_pulse: assert property (dma_fire |=> !dma_fire) else $error("dma_fire longer than one cycle");

   // Main scenarios seen
   c_run_read: cover property (rd && addr == MTC_OFS_RUN);
   c_dma_fire: cover property (dma_fire && dma_src == 3'h0);
   c_count_write: cover property (wr && addr == 8'h12 && wdata == 16'hffff);
endmodule

// file: test_multichannel_timer_status_count_start.sv
// Self-checking bench: host end and timer slice joined by the bus interface.
// Assumes software orders reach the host end on its command port.
module test_multichannel_timer_status_count_start;
   timeunit 1ns;
   timeprecision 1ps;
   import mtc_pkg::*;
   logic ref_clk, reset, cmd_wr, cmd_rd, cmd_rvalid, dma_done;
   logic [2:0] count_tick, phase_mode, count_down, pin_io_wr, wrap_irq_en, wrap_irq, dma_request_select;
   logic [7:0] is_capture, capture_in, match_level, pin_init, irq_enable_bits, capture_compare_pin, match_irq;
   logic [7:0] cmd_addr;
   logic [1:0] buffer_en, cmd_byte_en;
   logic [15:0] cmd_wdata, cmd_rdata;
   int errors = 0;
   int num_checks = 0;

   mtc_bus_if i_mtc_bus_if();
   mtc_timer_dev i_mtc_timer_dev(.ref_clk(ref_clk), .reset(reset), .b(i_mtc_bus_if), .count_tick(count_tick),
      .phase_mode(phase_mode), .count_down(count_down), .is_capture(is_capture), .capture_in(capture_in),
      .buffer_en(buffer_en), .match_level(match_level), .pin_io_wr(pin_io_wr), .pin_init(pin_init),
      .irq_enable_bits(irq_enable_bits), .wrap_irq_en(wrap_irq_en), .capture_compare_pin(capture_compare_pin),
      .match_irq(match_irq), .wrap_irq(wrap_irq));
   mtc_bus_host i_mtc_bus_host(.ref_clk(ref_clk), .reset(reset), .b(i_mtc_bus_if), .cmd_addr(cmd_addr),
      .cmd_wdata(cmd_wdata), .cmd_byte_en(cmd_byte_en), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata),
      .cmd_rvalid(cmd_rvalid), .dma_done(dma_done), .dma_request_select(dma_request_select));
   mtc_bus_monitor i_mtc_bus_monitor(.ref_clk(ref_clk), .reset(reset), .addr(i_mtc_bus_if.addr),
      .wdata(i_mtc_bus_if.wdata), .byte_en(i_mtc_bus_if.byte_en), .wr(i_mtc_bus_if.wr), .rd(i_mtc_bus_if.rd),
      .rdata(i_mtc_bus_if.rdata), .dma_fire(i_mtc_bus_if.dma_fire), .dma_src(i_mtc_bus_if.dma_src));

   // 25 MHz clock
   always #20 ref_clk = ~ref_clk;

   // Verdict and end of run
   task wrap_up();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // Compare one result
   task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One-cycle write strobe on the command port
   task wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      cmd_addr <= a;
      cmd_wdata <= d;
      cmd_wr <= 1'b1;
      @(posedge ref_clk);
      cmd_wr <= 1'b0;
   endtask

   // Read, wait for rvalid under a bound, compare the masked value
   task rc(input string nm, input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
      logic [15:0] v;
      v = 16'hxxxx;
      @(posedge ref_clk);
      cmd_addr <= a;
      cmd_rd <= 1'b1;
      @(posedge ref_clk);
      cmd_rd <= 1'b0;
      for (int n = 0; n < 6; n++) begin
         #1;
         if (cmd_rvalid === 1'b1) begin
            v = cmd_rdata;
            break;
         end
         @(posedge ref_clk);
      end
      chk(nm, e, v & m);
   endtask

   // Count ticks, one pulse every other cycle
   task tick(input int c, input int n);
      repeat (n) begin
         @(posedge ref_clk);
         count_tick[c] <= 1'b1;
         @(posedge ref_clk);
         count_tick[c] <= 1'b0;
      end
   endtask

   // Watchdog well beyond the two hundred or so cycles the tests take
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      wrap_up();
   end

   // Main sequence
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      {count_tick, phase_mode, count_down, pin_io_wr, wrap_irq_en, dma_request_select} = '0;
      {is_capture, capture_in, match_level, pin_init, irq_enable_bits, buffer_en} = '0;
      {cmd_addr, cmd_wdata, cmd_wr, cmd_rd, dma_done} = '0;
      cmd_byte_en = MTC_LANES_ALL;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      // Reset values and map
      rc("count0", 8'h02, MTC_COUNT_RST, 16'hffff);
      rc("gr0a", 8'h04, MTC_GR_RST, 16'hffff);
      rc("gr2b", 8'h26, MTC_GR_RST, 16'hffff);
      rc("run", 8'h30, 16'h0000, 16'h00ff);
      rc("unmapped", 8'h40, 16'h0000, 16'hffff);
      wr(8'h10, 16'h000c);
      rc("flags1_cd", 8'h10, 16'h0000, 16'h000c);
      wr(8'h30, 16'h00ff);
      rc("run_bits", 8'h30, 16'h0007, 16'hffff);
      wr(8'h30, 16'h0000);
      $display("test reset_and_run done");
      // Compare match, clear rules, interrupt, DMA, buffer
      match_level[0] <= 1'b1;
      irq_enable_bits[0] <= 1'b1;
      wr(8'h04, 16'h0003);
      wr(8'h30, 16'h0001);
      tick(0, 3);
      rc("count0", 8'h02, 16'h0003, 16'hffff);
      rc("flags0", 8'h00, 16'h00c1, 16'h00ff);
      chk("pin0", 16'h0001, {15'h0, capture_compare_pin[0]});
      chk("irq0", 16'h0001, {15'h0, match_irq[0]});
      wr(8'h00, 16'h00ff);
      rc("flags0_w1", 8'h00, 16'h00c1, 16'h00ff);
      wr(8'h00, 16'h00c0);
      rc("flags0_w0", 8'h00, 16'h00c0, 16'h00ff);
      buffer_en[0] <= 1'b1;
      wr(8'h08, 16'h0009);
      wr(8'h04, 16'h0005);
      tick(0, 2);
      rc("flags0_again", 8'h00, 16'h00c1, 16'h00ff);
      rc("gr0a_buf", 8'h04, 16'h0009, 16'hffff);
      // Zero write to an armed flag lands on the edge of a new match
      wr(8'h08, 16'h0020);
      tick(0, 3);
      fork
         wr(8'h00, 16'h00c0);
         begin
            @(posedge ref_clk);
            tick(0, 1);
         end
      join
      rc("flags0_race", 8'h00, 16'h00c1, 16'h00ff);
      rc("gr0a_buf2", 8'h04, 16'h0020, 16'hffff);
      @(posedge ref_clk);
      dma_done <= 1'b1;
      @(posedge ref_clk);
      dma_done <= 1'b0;
      rc("flags0_dma", 8'h00, 16'h00c0, 16'h00ff);
      wr(8'h30, 16'h0000);
      tick(0, 2);
      rc("count0_stop", 8'h02, 16'h0009, 16'hffff);
      chk("pin0_held", 16'h0001, {15'h0, capture_compare_pin[0]});
      @(posedge ref_clk);
      pin_io_wr[0] <= 1'b1;
      @(posedge ref_clk);
      pin_io_wr[0] <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("pin0_init", 16'h0000, {15'h0, capture_compare_pin[0]});
      $display("test compare done");
      // Capture on channel 1 register A
      is_capture[4] <= 1'b1;
      wr(8'h12, 16'h0100);
      @(posedge ref_clk);
      capture_in[4] <= 1'b1;
      @(posedge ref_clk);
      capture_in[4] <= 1'b0;
      rc("gr1a_cap", 8'h14, 16'h0100, 16'hffff);
      rc("flags1_cap", 8'h10, 16'h0001, 16'h000f);
      $display("test capture done");
      // Wrap, then down count in phase mode
      wrap_irq_en[1] <= 1'b1;
      wr(8'h12, 16'hffff);
      wr(8'h30, 16'h0002);
      tick(1, 1);
      rc("count1_wrap", 8'h12, 16'h0000, 16'hffff);
      rc("flags1_wrap", 8'h10, 16'h0010, 16'h0010);
      chk("wrap_irq1", 16'h0001, {15'h0, wrap_irq[1]});
      wr(8'h30, 16'h0000);
      phase_mode <= 3'h3;
      count_down <= 3'h3;
      wr(8'h02, 16'h0010);
      wr(8'h30, 16'h0003);
      tick(1, 1);
      tick(0, 1);
      rc("count1_down", 8'h12, 16'hffff, 16'hffff);
      rc("flags1_dir", 8'h10, 16'h0020, 16'h00a0);
      rc("count0_up", 8'h02, 16'h0011, 16'hffff);
      $display("test wrap_and_direction done");
      wrap_up();
   end
endmodule
